//--- clk_ctrl_pkg.sv
// Shared constants and types for the CPU clock source and divider block
package clk_ctrl_pkg;
    // ========================================================================
    // Register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_CLKDIV = 8'hD4;
    localparam logic [7:0] ADDR_OSCSEL = 8'hD8;
    localparam logic [7:0] ADDR_STPEN  = 8'hDC;
    localparam logic [7:0] ADDR_STATUS = 8'hE0;
    // ========================================================================
    // Field positions and writable masks
    localparam int unsigned DIV_LSB        = 3;
    localparam int unsigned SEL_SUB_BIT    = 0;
    localparam int unsigned SUB_STOP_BIT   = 2;
    localparam int unsigned MAIN_STOP_BIT  = 3;
    localparam logic [7:0]  CLKDIV_MASK    = 8'h98;
    localparam logic [7:0]  OSCSEL_MASK    = 8'h8D;
    // ========================================================================
    // Reset values
    localparam logic [7:0]  CLKDIV_RST     = 8'h00;
    localparam logic [7:0]  OSCSEL_RST     = 8'h00;
    localparam logic [7:0]  STPEN_RST      = 8'h00;
    localparam int unsigned FILTER_CYCLES  = 4;
    // ========================================================================
    // Divider codes and terminal counts (count of fxx ticks minus one)
    localparam logic [1:0]  DIV_BY16       = 2'h0;
    localparam logic [1:0]  DIV_BY8        = 2'h1;
    localparam logic [1:0]  DIV_BY2        = 2'h2;
    localparam logic [1:0]  DIV_BY1        = 2'h3;
    localparam logic [3:0]  TERM_BY16      = 4'hF;
    localparam logic [3:0]  TERM_BY8       = 4'h7;
    localparam logic [3:0]  TERM_BY2       = 4'h1;
    localparam logic [3:0]  TERM_BY1       = 4'h0;
    // ========================================================================
    // Bus responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // ========================================================================
    // Power modes, one-hot
    typedef enum logic [2:0] {
        MODE_RUN  = 3'b001,
        MODE_IDLE = 3'b010,
        MODE_STOP = 3'b100
    } pwr_mode_t;
    // Oscillator control fields taken from the select register
    typedef struct packed {
        logic sub_sel;
        logic sub_stop;
        logic main_stop;
    } osc_ctrl_t;
endpackage : clk_ctrl_pkg

//--- pin_sync.sv
// Three-flop pin synchroniser with agreement qualifier and rise pulse
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input  wire logic aclk,     // System clock
    input  wire logic aresetn,  // Synchronous reset, active low
    input  wire logic pin,      // Asynchronous pin
    output logic      level,    // Accepted level
    output logic      rise      // One-cycle pulse on accepted rise
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic rise_ff;
    wire  agree;
    wire  nxt_level;

    // ========================================================================
    // A change counts only once stages two and three agree
    assign agree     = (s2_ff == s3_ff);
    assign nxt_level = agree ? s3_ff : level_ff;

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
            rise_ff  <= 1'b0;
        end else begin
            s1_ff    <= pin;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            level_ff <= nxt_level;
            rise_ff  <= nxt_level & ~level_ff;
        end
    end

    assign level = level_ff;
    assign rise  = rise_ff;
endmodule : pin_sync
`default_nettype wire

//--- clk_divider.sv
// Programmable divider of the selected system clock tick stream
`timescale 1ns/10ps
`default_nettype none
module clk_divider (
    input  wire logic       aclk,     // System clock
    input  wire logic       aresetn,  // Synchronous reset, active low
    input  wire logic       tick_in,  // One tick per fxx edge
    input  wire logic       run,      // Counting allowed
    input  wire logic [1:0] div_code, // Ratio code
    output logic            tick_out  // One tick per CPU clock
);
    logic [3:0] cnt_ff;
    logic       out_ff;
    logic [3:0] term;
    wire        wrap;

    // ========================================================================
    // Code to terminal count
    always_comb begin
        unique case (div_code)
            clk_ctrl_pkg::DIV_BY16: term = clk_ctrl_pkg::TERM_BY16;
            clk_ctrl_pkg::DIV_BY8:  term = clk_ctrl_pkg::TERM_BY8;
            clk_ctrl_pkg::DIV_BY2:  term = clk_ctrl_pkg::TERM_BY2;
            clk_ctrl_pkg::DIV_BY1:  term = clk_ctrl_pkg::TERM_BY1;
        endcase
    end

    // A shrinking ratio never leaves the count stranded above term
    assign wrap = (cnt_ff >= term);

    // Count input ticks; gated ticks freeze the phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 4'h0;
            out_ff <= 1'b0;
        end else begin
            out_ff <= tick_in & run & wrap;
            if (tick_in & run) begin
                cnt_ff <= wrap ? 4'h0 : cnt_ff + 4'h1;
            end
        end
    end

    assign tick_out = out_ff;

    // ========================================================================
    property p_div_ratio;
        @(posedge aclk) disable iff (!aresetn)
        (tick_in && run && cnt_ff == term) |=> tick_out;
    endproperty
    a_div_ratio: assert property (p_div_ratio) else $error("divider missed wrap");

    property p_div_cause;
        @(posedge aclk) disable iff (!aresetn)
        tick_out |-> $past(tick_in) && $past(run);
    endproperty
    a_div_cause: assert property (p_div_cause) else $error("divider tick without cause");
endmodule : clk_divider
`default_nettype wire

//--- clk_ctrl.sv
// CPU clock source select, divider and power-down clock control
//
// Contract
// - CPU clock is fxx divided by 1,2,8,16
// - After reset the CPU runs at fxx/16
// - Select bit 0 picks main or sub
// - Main stop bit 3 halts main oscillator
// - Sub stop bit 2 halts sub oscillator
// - One write switches to sub, stops main
// - Main oscillator stays halted in Stop
// - Reset or filtered external interrupt ends Stop
// - Internal interrupt ends Stop if sub-clocked
// - Idle gates CPU clock, peripherals keep running
// - Any interrupt or reset ends Idle
// - Divider register read/write at D4H
// - Stop halts CPU and system clocks
`timescale 1ns/10ps
`default_nettype none
module clk_ctrl #(
    parameter int unsigned FILTER = clk_ctrl_pkg::FILTER_CYCLES // Noise filter cycles
) (
    input  wire logic        aclk,          // System clock, 200 MHz
    input  wire logic        aresetn,       // Synchronous reset, active low
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic        main_clock,    // Main oscillator pin
    input  wire logic        sub_clock,     // Sub oscillator pin
    input  wire logic        ext_irq,       // External interrupt pin
    input  wire logic        int_irq,       // Internal interrupt, same clock
    input  wire logic        wt_on_sub,     // Watch timer clocked by sub
    input  wire logic        stop_req,      // CPU enters Stop, pulse
    input  wire logic        idle_req,      // CPU enters Idle, pulse
    output logic             cpu_clk_en,    // CPU clock tick
    output logic             sys_clk_en,    // System and peripheral tick
    output logic             main_osc_en,   // Main oscillator enable
    output logic             sub_osc_en,    // Sub oscillator enable
    output logic             in_stop,       // Stop mode active
    output logic             in_idle        // Idle mode active
);
    // ========================================================================
    // Registers
    logic [7:0]  clkdiv_ff;
    logic [7:0]  oscsel_ff;
    logic [7:0]  stpen_ff;
    logic [7:0]  awaddr_ff;
    logic [7:0]  wdata_ff;
    logic        wstrb0_ff;
    logic        aw_have_ff;
    logic        w_have_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        sys_tick_ff;
    logic        main_en_ff;
    logic        sub_en_ff;
    logic [3:0]  flt_cnt_ff;
    logic        ext_ok_ff;
    clk_ctrl_pkg::pwr_mode_t mode_ff;
    clk_ctrl_pkg::pwr_mode_t nxt_mode;
    clk_ctrl_pkg::osc_ctrl_t osc;

    // ========================================================================
    // Pin synchronisers and divider
    wire main_rise;
    wire sub_rise;
    wire ext_level;
    wire cpu_tick;

    pin_sync u_sync_main (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (main_clock),
        .level   (),
        .rise    (main_rise)
    );

    pin_sync u_sync_sub (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (sub_clock),
        .level   (),
        .rise    (sub_rise)
    );

    pin_sync u_sync_ext (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (ext_irq),
        .level   (ext_level),
        .rise    ()
    );

    // ========================================================================
    // Bus handshake decode
    wire aw_take  = s_axi_awvalid & awready_ff;
    wire w_take   = s_axi_wvalid & wready_ff;
    wire ar_take  = s_axi_arvalid & arready_ff;
    wire do_write = aw_have_ff & w_have_ff & ~bvalid_ff;
    wire nxt_aw   = aw_take | (aw_have_ff & ~do_write);
    wire nxt_w    = w_take | (w_have_ff & ~do_write);
    wire nxt_rv   = ar_take | (rvalid_ff & ~s_axi_rready);
    wire wr_hit   = do_write & wstrb0_ff;
    wire wr_div   = wr_hit & (awaddr_ff == clk_ctrl_pkg::ADDR_CLKDIV);
    wire wr_osc   = wr_hit & (awaddr_ff == clk_ctrl_pkg::ADDR_OSCSEL);
    wire wr_stp   = wr_hit & (awaddr_ff == clk_ctrl_pkg::ADDR_STPEN);
    wire [7:0] nxt_oscsel = wr_osc ? (wdata_ff & clk_ctrl_pkg::OSCSEL_MASK) : oscsel_ff;
    wire aw_map   = (awaddr_ff == clk_ctrl_pkg::ADDR_CLKDIV) | (awaddr_ff == clk_ctrl_pkg::ADDR_OSCSEL)
                  | (awaddr_ff == clk_ctrl_pkg::ADDR_STPEN) | (awaddr_ff == clk_ctrl_pkg::ADDR_STATUS);

    // Read mux; status is read-only state of the block
    wire [7:0] status = {3'h0, mode_ff == clk_ctrl_pkg::MODE_STOP, mode_ff == clk_ctrl_pkg::MODE_IDLE,
                         sub_en_ff, main_en_ff, osc.sub_sel};
    wire ar_div   = (s_axi_araddr == clk_ctrl_pkg::ADDR_CLKDIV);
    wire ar_osc   = (s_axi_araddr == clk_ctrl_pkg::ADDR_OSCSEL);
    wire ar_stp   = (s_axi_araddr == clk_ctrl_pkg::ADDR_STPEN);
    wire ar_sts   = (s_axi_araddr == clk_ctrl_pkg::ADDR_STATUS);
    wire [7:0] rd_byte = ar_div ? clkdiv_ff : ar_osc ? oscsel_ff : ar_stp ? stpen_ff : ar_sts ? status : 8'h00;
    wire ar_map   = ar_div | ar_osc | ar_stp | ar_sts;

    // ========================================================================
    // Write side: address and data taken in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= clk_ctrl_pkg::RESP_OKAY;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 8'h00;
            wstrb0_ff  <= 1'b0;
        end else begin
            aw_have_ff <= nxt_aw;
            w_have_ff  <= nxt_w;
            awready_ff <= ~nxt_aw;
            wready_ff  <= ~nxt_w;
            bvalid_ff  <= do_write | (bvalid_ff & ~s_axi_bready);
            if (aw_take) awaddr_ff <= s_axi_awaddr;
            if (w_take) begin
                wdata_ff  <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (do_write) bresp_ff <= aw_map ? clk_ctrl_pkg::RESP_OKAY : clk_ctrl_pkg::RESP_SLVERR;
        end
    end

    // Read side: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= clk_ctrl_pkg::RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rv;
            rvalid_ff  <= nxt_rv;
            if (ar_take) begin
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= ar_map ? clk_ctrl_pkg::RESP_OKAY : clk_ctrl_pkg::RESP_SLVERR;
            end
        end
    end

    // ========================================================================
    // Control registers; all fields change in one write so a switch is atomic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clkdiv_ff <= clk_ctrl_pkg::CLKDIV_RST;
            oscsel_ff <= clk_ctrl_pkg::OSCSEL_RST;
            stpen_ff  <= clk_ctrl_pkg::STPEN_RST;
        end else begin
            if (wr_div) clkdiv_ff <= wdata_ff & clk_ctrl_pkg::CLKDIV_MASK;
            oscsel_ff <= nxt_oscsel;
            if (wr_stp) stpen_ff  <= wdata_ff;
        end
    end

    assign osc.sub_sel   = oscsel_ff[clk_ctrl_pkg::SEL_SUB_BIT];
    assign osc.sub_stop  = oscsel_ff[clk_ctrl_pkg::SUB_STOP_BIT];
    assign osc.main_stop = oscsel_ff[clk_ctrl_pkg::MAIN_STOP_BIT];

    // ========================================================================
    // External wake passes a delay filter so short glitches are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_cnt_ff <= 4'h0;
            ext_ok_ff  <= 1'b0;
        end else begin
            flt_cnt_ff <= !ext_level ? 4'h0 : (flt_cnt_ff == 4'(FILTER)) ? flt_cnt_ff : flt_cnt_ff + 4'h1;
            ext_ok_ff  <= ext_level & (flt_cnt_ff == 4'(FILTER - 1));
        end
    end

    // ========================================================================
    // Power mode sequencing
    wire int_wake = int_irq & sub_en_ff & wt_on_sub;
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            clk_ctrl_pkg::MODE_RUN: begin
                if (stop_req) nxt_mode = clk_ctrl_pkg::MODE_STOP;
                else if (idle_req) nxt_mode = clk_ctrl_pkg::MODE_IDLE;
            end
            clk_ctrl_pkg::MODE_IDLE: begin
                if (ext_ok_ff | int_irq) nxt_mode = clk_ctrl_pkg::MODE_RUN;
            end
            clk_ctrl_pkg::MODE_STOP: begin
                if (ext_ok_ff | int_wake) nxt_mode = clk_ctrl_pkg::MODE_RUN;
            end
            default: nxt_mode = clk_ctrl_pkg::MODE_RUN;
        endcase
    end

    // Source select; a stopped oscillator yields no ticks even if its pin toggles
    wire fxx_tick = osc.sub_sel ? (sub_rise & sub_en_ff) : (main_rise & main_en_ff);
    wire not_stop = (mode_ff != clk_ctrl_pkg::MODE_STOP);
    // Enables follow the register in the same edge, so a switch never lags
    wire nxt_main_on = ~nxt_oscsel[clk_ctrl_pkg::MAIN_STOP_BIT] & (nxt_mode != clk_ctrl_pkg::MODE_STOP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff     <= clk_ctrl_pkg::MODE_RUN;
            main_en_ff  <= 1'b1;
            sub_en_ff   <= 1'b1;
            sys_tick_ff <= 1'b0;
        end else begin
            mode_ff     <= nxt_mode;
            main_en_ff  <= nxt_main_on;
            sub_en_ff   <= ~nxt_oscsel[clk_ctrl_pkg::SUB_STOP_BIT];
            sys_tick_ff <= fxx_tick & not_stop;
        end
    end

    // CPU ticks only in Run; Idle and Stop freeze the divider phase
    clk_divider u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick_in  (fxx_tick),
        .run      (mode_ff == clk_ctrl_pkg::MODE_RUN),
        .div_code (clkdiv_ff[clk_ctrl_pkg::DIV_LSB +: 2]),
        .tick_out (cpu_tick)
    );

    // ========================================================================
    // Outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign cpu_clk_en    = cpu_tick;
    assign sys_clk_en    = sys_tick_ff;
    assign main_osc_en   = main_en_ff;
    assign sub_osc_en    = sub_en_ff;
    assign in_stop       = (mode_ff == clk_ctrl_pkg::MODE_STOP);
    assign in_idle       = (mode_ff == clk_ctrl_pkg::MODE_IDLE);

    // ========================================================================
    // Checks
    property p_stop_gate;
        @(posedge aclk) disable iff (!aresetn)
        (mode_ff == clk_ctrl_pkg::MODE_STOP)[*2] |-> !cpu_clk_en && !sys_clk_en;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("clock ran in stop");

    property p_main_osc;
        @(posedge aclk) disable iff (!aresetn)
        main_osc_en == (!oscsel_ff[clk_ctrl_pkg::MAIN_STOP_BIT] && mode_ff != clk_ctrl_pkg::MODE_STOP);
    endproperty
    a_main_osc: assert property (p_main_osc) else $error("main oscillator enable wrong");

    property p_sub_osc;
        @(posedge aclk) disable iff (!aresetn)
        $changed(oscsel_ff[clk_ctrl_pkg::SUB_STOP_BIT]) |-> sub_osc_en == !oscsel_ff[clk_ctrl_pkg::SUB_STOP_BIT];
    endproperty
    a_sub_osc: assert property (p_sub_osc) else $error("sub oscillator enable wrong");

    property p_src_sel;
        @(posedge aclk) disable iff (!aresetn)
        (osc.sub_sel && !sub_rise) |=> !sys_clk_en;
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("tick from wrong source");

    property p_idle_gate;
        @(posedge aclk) disable iff (!aresetn)
        (mode_ff == clk_ctrl_pkg::MODE_IDLE && !osc.sub_sel && main_en_ff && main_rise)
            |=> sys_clk_en && !cpu_clk_en;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");

    property p_idle_wake;
        @(posedge aclk) disable iff (!aresetn)
        (mode_ff == clk_ctrl_pkg::MODE_IDLE && int_irq) |=> mode_ff == clk_ctrl_pkg::MODE_RUN;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not released");

    property p_stop_int;
        @(posedge aclk) disable iff (!aresetn)
        (mode_ff == clk_ctrl_pkg::MODE_STOP && int_irq && !ext_ok_ff)
            |=> (mode_ff == clk_ctrl_pkg::MODE_RUN) == $past(sub_en_ff && wt_on_sub);
    endproperty
    a_stop_int: assert property (p_stop_int) else $error("internal stop release wrong");

    property p_stop_ext;
        @(posedge aclk) disable iff (!aresetn)
        (mode_ff == clk_ctrl_pkg::MODE_STOP && ext_ok_ff) |=> main_osc_en == !osc.main_stop && !in_stop;
    endproperty
    a_stop_ext: assert property (p_stop_ext) else $error("external stop release wrong");

    property p_reset_div;
        @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> clkdiv_ff[clk_ctrl_pkg::DIV_LSB +: 2] == clk_ctrl_pkg::DIV_BY16;
    endproperty
    a_reset_div: assert property (p_reset_div) else $error("divider not slowest after reset");

    property p_switch_sub;
        @(posedge aclk) disable iff (!aresetn)
        (wr_osc && wdata_ff[clk_ctrl_pkg::SEL_SUB_BIT] && wdata_ff[clk_ctrl_pkg::MAIN_STOP_BIT])
            |=> osc.sub_sel && !main_osc_en;
    endproperty
    a_switch_sub: assert property (p_switch_sub) else $error("switch to sub failed");

    property p_div_read;
        @(posedge aclk) disable iff (!aresetn)
        (ar_take && ar_div && !wr_div) |=> s_axi_rvalid && s_axi_rdata[7:0] == clkdiv_ff;
    endproperty
    a_div_read: assert property (p_div_read) else $error("divider register read wrong");
endmodule : clk_ctrl
`default_nettype wire

//--- osc_model.sv
// Behavioural oscillator standing in for a crystal or external clock source
`timescale 1ns/10ps
`default_nettype none
module osc_model #(
    parameter int HALF_NS = 11 // Half period in ns
) (
    input  wire logic run,    // Oscillator enable from the block
    output logic      osc_out // Oscillator pin
);
    // Stands still while halted, as a stopped crystal would
    initial osc_out = 1'h0;
    always #(HALF_NS) if (run) osc_out = ~osc_out;
endmodule : osc_model
`default_nettype wire

//--- cpu_clock_source_and_divider_tb_top.sv
// Self-checking bench for the clock source, divider and power-down control
`timescale 1ns/10ps
`default_nettype none
module cpu_clock_source_and_divider_tb_top;
    logic        aclk = 1'h0, aresetn = 1'h0, ext_irq = 1'h0, int_irq = 1'h0, wt_on_sub = 1'h0;
    logic        stop_req = 1'h0, idle_req = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, main_clock, sub_clock;
    logic        cpu_clk_en, sys_clk_en, main_osc_en, sub_osc_en, in_stop, in_idle;
    int          errors = 0, comparisons = 0, cycles = 0, ncpu, nsys;
    int          rt[4] = '{16, 8, 2, 1};
    // ========================================================================
    // Design, oscillators and clock
    clk_ctrl #(.FILTER(2)) i_clk_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .main_clock, .sub_clock, .ext_irq, .int_irq, .wt_on_sub, .stop_req, .idle_req, .cpu_clk_en,
        .sys_clk_en, .main_osc_en, .sub_osc_en, .in_stop, .in_idle);
    osc_model #(.HALF_NS(11)) i_main_osc (.run(main_osc_en), .osc_out(main_clock));
    osc_model #(.HALF_NS(29)) i_sub_osc (.run(sub_osc_en), .osc_out(sub_clock));
    initial forever #2.5 aclk = ~aclk;
    // Hang guard, well above the thousand or so cycles the tests take
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // ========================================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        check(32'(s_axi_bresp), 32'(resp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        check(s_axi_rdata, {24'h0, exp});
        check(32'(s_axi_rresp), 32'(resp));
    endtask : rd
    // First period after a ratio change may be short, so it is skipped
    task automatic ratio(input int exp);
        nsys = 0;
        repeat (2) do @(posedge aclk); while (!cpu_clk_en);
        do begin
            @(posedge aclk);
            nsys += sys_clk_en;
        end while (!cpu_clk_en);
        check(32'(nsys), 32'(exp));
    endtask : ratio
    task automatic count(input int c);
        ncpu = 0;
        nsys = 0;
        repeat (c) begin
            @(posedge aclk);
            ncpu += cpu_clk_en;
            nsys += sys_clk_en;
        end
    endtask : count
    task automatic mode_req(input logic stop);
        if (stop) stop_req <= 1'h1;
        else idle_req <= 1'h1;
        @(posedge aclk);
        stop_req <= 1'h0;
        idle_req <= 1'h0;
        @(posedge aclk);
    endtask : mode_req
    task automatic nudge();
        int_irq <= 1'h1;
        @(posedge aclk);
        int_irq <= 1'h0;
        repeat (20) @(posedge aclk);
    endtask : nudge
    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // ========================================================================
    // Test sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(clk_ctrl_pkg::ADDR_CLKDIV, clk_ctrl_pkg::CLKDIV_RST, clk_ctrl_pkg::RESP_OKAY);
        rd(clk_ctrl_pkg::ADDR_STATUS, 8'h06, clk_ctrl_pkg::RESP_OKAY);
        ratio(16);
        rd(clk_ctrl_pkg::ADDR_STPEN, clk_ctrl_pkg::STPEN_RST, clk_ctrl_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(clk_ctrl_pkg::ADDR_CLKDIV, 8'(i << 3), clk_ctrl_pkg::RESP_OKAY);
            ratio(rt[i]);
        end
        wr(clk_ctrl_pkg::ADDR_CLKDIV, 8'hFF, clk_ctrl_pkg::RESP_OKAY);
        rd(clk_ctrl_pkg::ADDR_CLKDIV, clk_ctrl_pkg::CLKDIV_MASK, clk_ctrl_pkg::RESP_OKAY);
        mode_req(1'h0);
        check(32'(in_idle), 32'h1);
        count(64);
        check(32'(ncpu), 32'h0);
        check(32'(nsys > 4), 32'h1);
        nudge();
        check(32'(in_idle), 32'h0);
        mode_req(1'h1);
        check(32'(main_osc_en), 32'h0);
        count(64);
        check(32'(ncpu + nsys), 32'h0);
        nudge();
        check(32'(in_stop), 32'h1);
        wt_on_sub <= 1'h1;
        nudge();
        check(32'(in_stop), 32'h0);
        mode_req(1'h1);
        ext_irq <= 1'h1;
        repeat (30) @(posedge aclk);
        ext_irq <= 1'h0;
        check(32'({in_stop, main_osc_en}), 32'h1);
        wr(clk_ctrl_pkg::ADDR_CLKDIV, 8'h18, clk_ctrl_pkg::RESP_OKAY);
        wr(clk_ctrl_pkg::ADDR_OSCSEL, 8'h09, clk_ctrl_pkg::RESP_OKAY);
        check(32'(main_osc_en), 32'h0);
        rd(clk_ctrl_pkg::ADDR_STATUS, 8'h05, clk_ctrl_pkg::RESP_OKAY);
        ratio(1);
        wr(clk_ctrl_pkg::ADDR_OSCSEL, 8'h01, clk_ctrl_pkg::RESP_OKAY);
        check(32'(main_osc_en), 32'h1);
        repeat (200) @(posedge aclk);
        wr(clk_ctrl_pkg::ADDR_OSCSEL, 8'h00, clk_ctrl_pkg::RESP_OKAY);
        rd(clk_ctrl_pkg::ADDR_STATUS, 8'h06, clk_ctrl_pkg::RESP_OKAY);
        wr(clk_ctrl_pkg::ADDR_OSCSEL, 8'h04, clk_ctrl_pkg::RESP_OKAY);
        check(32'(sub_osc_en), 32'h0);
        rd(8'h40, 8'h00, clk_ctrl_pkg::RESP_SLVERR);
        report_and_stop();
    end
endmodule : cpu_clock_source_and_divider_tb_top
`default_nettype wire
